// [hw/gated_counter.sv]
// gated 16-bit counter with gate modes, flags and time-base hooks
`timescale 1ns/10ps
`include "gate_counter_consts.svh"
module gated_counter
(
    input  wire logic        mclk_in,             // system clock 40 MHz
    input  wire logic        rst_in,              // sync reset, high
    input  wire logic        count_tick_in,       // counter clock enable
    input  wire logic        counter_on_in,       // counter on bit
    input  wire gate_counter_pkg::gate_cfg_t gate_cfg_in, // gate config
    input  wire gate_counter_pkg::irq_cfg_t  irq_cfg_in,  // irq enables
    input  wire logic        cmp_sync_in,         // comparator sync select
    input  wire logic        external_sync_disable_in, // async ext clock
    input  wire logic        ext_clock_sel_in,    // external clock chosen
    input  wire logic        low_freq_osc_enable_in, // oscillator enable
    input  wire logic        sleep_in,            // device asleep
    input  wire logic        gate_input_pin_in,   // gate pin, async
    input  wire logic [7:0]  eight_bit_timer_count_in, // eight-bit timer
    input  wire logic        comparator_one_output_in, // comparator one
    input  wire logic        comparator_two_output_in, // comparator two
    input  wire logic        arm_set_in,          // pulse: set arm bit
    input  wire logic        arm_clear_in,        // pulse: clear arm bit
    input  wire logic        gate_flag_clear_in,  // pulse: clear gate flag
    input  wire logic        ovf_flag_clear_in,   // pulse: clear overflow
    input  wire logic        wr_low_in,           // pulse: write low byte
    input  wire logic        wr_high_in,          // pulse: write high byte
    input  wire logic [7:0]  wr_data_in,          // written byte
    input  wire logic        capture_mode_in,     // capture mode select
    input  wire logic        capture_event_in,    // pulse: capture event
    input  wire logic        compare_mode_in,     // compare mode select
    input  wire logic        special_trig_en_in,  // match clears counter
    input  wire logic [15:0] compare_value_in,    // compare pair value
    output logic [7:0]       count_low_byte_out,  // count low byte
    output logic [7:0]       count_high_byte_out, // count high byte
    output logic [15:0]      compare_capture_pair_out, // captured count
    output logic             compare_event_out,   // compare match pulse
    output logic             gate_pulse_arm_out,  // arm bit status
    output logic             gate_level_status_out, // gate level
    output logic             gate_event_flag_out, // gate event flag
    output logic             overflow_flag_out,   // overflow flag
    output logic             irq_out,             // interrupt request
    output logic             wake_out,            // wake from sleep
    output logic             osc_run_out          // oscillator running
);
    import gate_counter_pkg::*;
    // ---------------------------------------------
    // declarations
    // ---------------------------------------------
    logic                  pin_sync;      // synchronised pin
    logic                  cmp1_async;    // comparator one, synced
    logic                  cmp2_async;    // comparator two, synced
    logic                  cmp1_sel;      // comparator one chosen form
    logic                  cmp2_sel;      // comparator two chosen form
    logic                  gate_src;      // selected raw gate
    logic                  gate_pol;      // gate after polarity
    logic                  gate_pol_prev_reg; // previous polarised gate
    logic                  gate_rise;     // incrementing edge
    logic                  toggle_reg;    // toggle flip-flop
    logic                  tog_level;     // gate after toggle stage
    logic                  tog_prev_reg;  // previous toggle level
    logic                  tog_rise;      // toggle stage rising
    logic                  tog_fall;      // toggle stage trailing
    sp_state_t             sp_reg;        // single-pulse state
    sp_state_t             sp_next;       // next single-pulse state
    logic                  arm_reg;       // arm bit
    logic                  gate_val;      // final gate control value
    logic                  gate_val_reg;  // gate level status
    logic                  gate_flag_reg; // gate event flag
    logic                  ovf_flag_reg;  // overflow flag
    logic [`CNT_WIDTH-1:0] count_reg;     // the counter
    logic [`CNT_WIDTH-1:0] capture_reg;   // capture pair
    logic                  match;         // compare match
    logic                  match_prev_reg; // match last cycle
    logic                  match_pulse;   // match rising
    logic                  run_ok;        // allowed to run (sleep)
    logic                  count_en;      // increment this cycle
    // ---------------------------------------------
    // input synchronisers
    // ---------------------------------------------
    // synchronise pin
    sync2 u_pin_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    (gate_input_pin_in),
        .q_out   (pin_sync)
    );
    sync2 u_cmp1_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    (comparator_one_output_in),
        .q_out   (cmp1_async)
    );
    sync2 u_cmp2_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    (comparator_two_output_in),
        .q_out   (cmp2_async)
    );
    assign cmp1_sel = cmp_sync_in ? comparator_one_output_in : cmp1_async;
    assign cmp2_sel = cmp_sync_in ? comparator_two_output_in : cmp2_async;
    // ---------------------------------------------
    // gate source selection
    // ---------------------------------------------
    // source mux
    gate_source_mux u_mux (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .select_in (gate_cfg_in.gate_source_select),
        .pin_in    (pin_sync),
        .tmr8_in   (eight_bit_timer_count_in),
        .cmp1_in   (cmp1_sel),
        .cmp2_in   (cmp2_sel),
        .gate_out  (gate_src)
    );
    assign gate_pol  = gate_cfg_in.gate_polarity ? gate_src : ~gate_src;
    assign gate_rise = gate_pol & ~gate_pol_prev_reg;
    // ---------------------------------------------
    // edge history
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gate_pol_prev_reg <= 1'b0;
            tog_prev_reg      <= 1'b0;
        end else begin
            gate_pol_prev_reg <= gate_pol;
            tog_prev_reg      <= tog_level;
        end
    end
    // ---------------------------------------------
    // toggle flip-flop
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            toggle_reg <= 1'b0;
        end else if (!gate_cfg_in.gate_toggle_enable || !counter_on_in) begin
            toggle_reg <= 1'b0;
        end else if (gate_rise) begin
            toggle_reg <= ~toggle_reg;
        end
    end
    // toggle output is the flip-flop's next value so gating is timely
    assign tog_level = gate_cfg_in.gate_toggle_enable ?
                       (toggle_reg ^ gate_rise) : gate_pol;
    assign tog_rise  = tog_level & ~tog_prev_reg;
    assign tog_fall  = ~tog_level & tog_prev_reg;
    // ---------------------------------------------
    // single-pulse machine
    // ---------------------------------------------
    always_comb begin
        sp_next = sp_reg;
        case (sp_reg)
            SP_IDLE: begin
                if (gate_cfg_in.gate_single_pulse_enable && arm_reg) begin
                    sp_next = SP_WAIT;
                end
            end
            SP_WAIT: begin
                if (!gate_cfg_in.gate_single_pulse_enable || !arm_reg) begin
                    sp_next = SP_IDLE;
                end else if (tog_rise) begin
                    sp_next = SP_RUN;
                end
            end
            SP_RUN: begin
                if (tog_fall || !gate_cfg_in.gate_single_pulse_enable ||
                    !arm_reg) begin
                    sp_next = SP_IDLE;
                end
            end
            default: sp_next = SP_IDLE;
        endcase
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sp_reg <= SP_IDLE;
        end else begin
            sp_reg <= sp_next;
        end
    end
    // arm bit: the hardware clear on the trailing edge
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            arm_reg <= 1'b0;
        end else if (arm_set_in) begin
            arm_reg <= 1'b1;
        end else if (arm_clear_in) begin
            arm_reg <= 1'b0;
        end else if (sp_reg == SP_RUN && tog_fall) begin
            arm_reg <= 1'b0;
        end
    end
    assign gate_val = gate_cfg_in.gate_single_pulse_enable ?
                      (tog_level && (sp_reg == SP_RUN ||
                       (sp_reg == SP_WAIT && tog_rise))) : tog_level;
    // ---------------------------------------------
    // gate status and event flag
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gate_val_reg <= 1'b0;
        end else begin
            gate_val_reg <= gate_val;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gate_flag_reg <= 1'b0;
        end else if (gate_val_reg && !gate_val) begin
            gate_flag_reg <= 1'b1;
        end else if (gate_flag_clear_in) begin
            gate_flag_reg <= 1'b0;
        end
    end
    // ---------------------------------------------
    // counter
    // ---------------------------------------------
    // sleep needs unsynchronised external clock
    assign run_ok   = !sleep_in ||
                      (ext_clock_sel_in && external_sync_disable_in);
    assign count_en = counter_on_in && count_tick_in && run_ok &&
                      (!gate_cfg_in.gate_enable || gate_val);
    assign match    = compare_mode_in && (count_reg == compare_value_in);
    assign match_pulse = match && !match_prev_reg;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            count_reg <= `CNT_ZERO;
        end else if (wr_low_in || wr_high_in) begin
            if (wr_low_in) begin
                count_reg[7:0] <= wr_data_in;
            end
            if (wr_high_in) begin
                count_reg[15:8] <= wr_data_in;
            end
        end else if (match_pulse && special_trig_en_in) begin
            count_reg <= `CNT_ZERO;
        end else if (count_en) begin
            count_reg <= count_reg + 16'h0001;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ovf_flag_reg <= 1'b0;
        end else if (count_en && count_reg == `CNT_MAX &&
                     !wr_low_in && !wr_high_in &&
                     !(match_pulse && special_trig_en_in)) begin
            ovf_flag_reg <= 1'b1;
        end else if (ovf_flag_clear_in) begin
            ovf_flag_reg <= 1'b0;
        end
    end
    // ---------------------------------------------
    // capture and compare
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            capture_reg <= `CNT_ZERO;
        end else if (capture_mode_in && capture_event_in) begin
            capture_reg <= count_reg;
        end
    end
    assign compare_event_out = match_pulse;
    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    assign count_low_byte_out       = count_reg[7:0];
    assign count_high_byte_out      = count_reg[15:8];
    assign compare_capture_pair_out = capture_reg;
    assign gate_pulse_arm_out       = arm_reg;
    assign gate_level_status_out    = gate_val_reg;
    assign gate_event_flag_out      = gate_flag_reg;
    assign overflow_flag_out        = ovf_flag_reg;
    assign irq_out = irq_cfg_in.peripheral_irq_enable &&
                     irq_cfg_in.global_irq_enable &&
                     ((counter_on_in && irq_cfg_in.overflow_irq_enable &&
                       ovf_flag_reg) ||
                      (irq_cfg_in.gate_event_irq_enable && gate_flag_reg));
    assign wake_out = sleep_in && counter_on_in &&
                      irq_cfg_in.overflow_irq_enable &&
                      irq_cfg_in.peripheral_irq_enable && ovf_flag_reg;
    assign osc_run_out = low_freq_osc_enable_in;
endmodule // gated_counter

// [shared/gate_counter_consts.svh]
// constants for the gated 16-bit counter
`ifndef GATE_COUNTER_CONSTS_SVH
`define GATE_COUNTER_CONSTS_SVH
`define CNT_WIDTH        16
`define CNT_ZERO         16'h0000
`define CNT_MAX          16'hFFFF
`define TMR8_MAX         8'hFF
`define TMR8_ZERO        8'h00
`define SRC_PIN          2'h0
`define SRC_TMR8         2'h1
`define SRC_CMP1         2'h2
`define SRC_CMP2         2'h3
`endif

// [shared/gate_counter_pkg.sv]
// types for the gated 16-bit counter
package gate_counter_pkg;
    // gate configuration bits from software
    typedef struct packed {
        logic       gate_enable;
        logic       gate_polarity;
        logic       gate_toggle_enable;
        logic       gate_single_pulse_enable;
        logic [1:0] gate_source_select;
    } gate_cfg_t;
    // interrupt enables from software
    typedef struct packed {
        logic overflow_irq_enable;
        logic gate_event_irq_enable;
        logic peripheral_irq_enable;
        logic global_irq_enable;
    } irq_cfg_t;
    // single-pulse machine states
    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_WAIT = 3'b010,
        SP_RUN  = 3'b100
    } sp_state_t;
endpackage

// [hw/sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/10ps
module sync2 (
    input  wire logic mclk_in,  // system clock
    input  wire logic rst_in,   // sync reset
    input  wire logic d_in,     // async level
    output logic      q_out     // synchronised level
);
    logic meta_reg;  // first stage, read only by second
    logic q_reg;     // second stage
    // ---------------------------------------------
    // two-stage capture
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            meta_reg <= 1'b0;
            q_reg    <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_reg    <= meta_reg;
        end
    end
    assign q_out = q_reg;
endmodule // sync2

// [hw/gate_source_mux.sv]
// gate source selection and timer wrap pulse
`timescale 1ns/10ps
`include "gate_counter_consts.svh"
module gate_source_mux (
    input  wire logic       mclk_in,     // system clock
    input  wire logic       rst_in,      // sync reset
    input  wire logic [1:0] select_in,   // gate source select
    input  wire logic       pin_in,      // synchronised gate pin
    input  wire logic [7:0] tmr8_in,     // eight-bit timer count
    input  wire logic       cmp1_in,     // comparator one level
    input  wire logic       cmp2_in,     // comparator two level
    output logic            gate_out     // selected gate level
);
    logic [7:0] tmr8_prev_reg;  // last timer value
    logic       wrap_pulse;     // timer wrapped this cycle
    logic       gate_reg;       // registered selection
    // ---------------------------------------------
    // timer wrap detect
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tmr8_prev_reg <= `TMR8_ZERO;
        end else begin
            tmr8_prev_reg <= tmr8_in;
        end
    end
    assign wrap_pulse = (tmr8_prev_reg == `TMR8_MAX) &&
                        (tmr8_in == `TMR8_ZERO);
    // ---------------------------------------------
    // source mux
    // ---------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gate_reg <= 1'b0;
        end else begin
            case (select_in)
                `SRC_PIN:  gate_reg <= pin_in;
                `SRC_TMR8: gate_reg <= wrap_pulse;
                `SRC_CMP1: gate_reg <= cmp1_in;
                `SRC_CMP2: gate_reg <= cmp2_in;
                default:   gate_reg <= 1'b0;
            endcase
        end
    end
    assign gate_out = gate_reg;
endmodule // gate_source_mux

// [dv/gate_source_model.sv]
// far-side model: gate pin, two comparators and the eight-bit timer
`timescale 1ns/10ps
module gate_source_model (
    input  wire logic       mclk_in,    // system clock
    input  wire logic       pin_cmd_in, // wanted gate pin level
    input  wire logic       c1_cmd_in,  // wanted comparator one level
    input  wire logic       c2_cmd_in,  // wanted comparator two level
    input  wire logic       tmr_run_in, // let the timer count
    output logic            pin_out,    // gate pin level
    output logic            cmp1_out,   // comparator one level
    output logic            cmp2_out,   // comparator two level
    output logic [7:0]      tmr8_out    // eight-bit timer count
);
    // levels move on the falling edge, clear of the sampling edge
    always @(negedge mclk_in) begin
        pin_out <= pin_cmd_in;
        cmp1_out <= c1_cmd_in;
        cmp2_out <= c2_cmd_in;
    end
    // timer counts only while tmr_run_in is high, wraps from all ones to zero by itself
    initial tmr8_out = 8'h00;
    always @(negedge mclk_in) begin
        if (tmr_run_in) begin
            tmr8_out <= tmr8_out + 8'h01;
        end
    end
endmodule // gate_source_model

// [dv/gated_counter_chk.sv]
// port assertions for the gated counter
`timescale 1ns/10ps
module gated_counter_chk
    import gate_counter_pkg::*;
(
    input wire logic        mclk_in, rst_in, count_tick_in, counter_on_in,
    input wire gate_counter_pkg::gate_cfg_t gate_cfg_in,
    input wire gate_counter_pkg::irq_cfg_t  irq_cfg_in,
    input wire logic        sleep_in, low_freq_osc_enable_in,
    input wire logic        ovf_flag_clear_in, arm_set_in, arm_clear_in,
    input wire logic        wr_low_in, wr_high_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic        capture_mode_in, capture_event_in,
    input wire logic        compare_mode_in, special_trig_en_in,
    input wire logic [7:0]  count_low_byte_out, count_high_byte_out,
    input wire logic [15:0] compare_capture_pair_out,
    input wire logic        compare_event_out, gate_pulse_arm_out,
    input wire logic        gate_level_status_out, gate_event_flag_out,
    input wire logic        overflow_flag_out, irq_out, osc_run_out
);
    wire [15:0] cnt = {count_high_byte_out, count_low_byte_out};
    wire        wr  = wr_low_in | wr_high_in;
    wire        run = counter_on_in & ~sleep_in & ~wr & ~special_trig_en_in;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_free_count: assert property (run && !gate_cfg_in.gate_enable
        && count_tick_in && cnt != 16'hFFFF |=> cnt == $past(cnt) + 16'h0001)
        else $error("count did not step");
    a_off_hold: assert property (!counter_on_in && !wr
        && !special_trig_en_in |=> $stable(cnt)) else $error("count moved");
    a_ovf_wrap: assert property (run && !gate_cfg_in.gate_enable
        && count_tick_in && cnt == 16'hFFFF |=> cnt == 16'h0000
        && overflow_flag_out) else $error("wrap missed");
    a_ovf_stands: assert property (overflow_flag_out
        && !ovf_flag_clear_in |=> overflow_flag_out) else $error("flag lost");
    a_irq_terms: assert property (irq_out == (irq_cfg_in.peripheral_irq_enable
        && irq_cfg_in.global_irq_enable && ((overflow_flag_out
        && irq_cfg_in.overflow_irq_enable && counter_on_in)
        || (gate_event_flag_out && irq_cfg_in.gate_event_irq_enable))))
        else $error("irq mismatch");
    a_gate_event: assert property ($fell(gate_level_status_out)
        |-> ##[0:1] gate_event_flag_out) else $error("gate flag missed");
    a_arm_set: assert property (arm_set_in && !arm_clear_in
        |=> gate_pulse_arm_out) else $error("arm not set");
    a_write_low: assert property (wr_low_in
        |=> count_low_byte_out == $past(wr_data_in)) else $error("write lost");
    a_capture_copy: assert property (capture_mode_in && capture_event_in
        |=> compare_capture_pair_out == $past(cnt)) else $error("capture bad");
    a_trig_clear: assert property (compare_mode_in && special_trig_en_in
        && compare_event_out && !wr |=> cnt == 16'h0000
        && !$rose(overflow_flag_out)) else $error("trigger clear bad");
    a_osc_run: assert property (osc_run_out == low_freq_osc_enable_in)
        else $error("oscillator state");
    c_wrap: cover property ($rose(overflow_flag_out));
    c_pulse: cover property ($fell(gate_pulse_arm_out));
    c_trig: cover property (compare_event_out && special_trig_en_in);
endmodule // gated_counter_chk
bind gated_counter gated_counter_chk u_chk (.*);

// [dv/tb_gated_counter.sv]
// self-checking bench for the gated counter
`timescale 1ns/10ps
module tb_gated_counter;
    import gate_counter_pkg::*;
    logic mclk_in = '0, rst_in = '1, count_tick_in = '0, counter_on_in = '0,
        cmp_sync_in = '0, external_sync_disable_in = '0, ext_clock_sel_in = '0,
        low_freq_osc_enable_in = '0, sleep_in = '0, arm_set_in = '0,
        arm_clear_in = '0, gate_flag_clear_in = '0, ovf_flag_clear_in = '0,
        wr_low_in = '0, wr_high_in = '0, capture_mode_in = '0,
        capture_event_in = '0, compare_mode_in = '0, special_trig_en_in = '0,
        pin_cmd = '0, c1_cmd = '0, c2_cmd = '0, tmr_run = '0;
    logic [7:0]  wr_data_in = '0;          // byte for counter writes
    logic [15:0] compare_value_in = '0;    // compare pair
    logic [15:0] held;                     // count kept for comparison
    gate_cfg_t   gate_cfg_in = '0;         // gate configuration
    irq_cfg_t    irq_cfg_in = '0;          // interrupt enables
    logic gate_input_pin_in, comparator_one_output_in, comparator_two_output_in;
    logic [7:0]  eight_bit_timer_count_in, count_low_byte_out, count_high_byte_out;
    logic [15:0] compare_capture_pair_out;
    logic compare_event_out, gate_pulse_arm_out, gate_level_status_out,
        gate_event_flag_out, overflow_flag_out, irq_out, wake_out, osc_run_out;
    int err_total = 0;
    int compares = 0;
    wire [15:0] cnt = {count_high_byte_out, count_low_byte_out};
    always #12.5 mclk_in = ~mclk_in;
    gated_counter u_dut (.*);
    gate_source_model u_src (.mclk_in, .pin_cmd_in(pin_cmd),
        .c1_cmd_in(c1_cmd), .c2_cmd_in(c2_cmd), .tmr_run_in(tmr_run),
        .pin_out(gate_input_pin_in), .cmp1_out(comparator_one_output_in),
        .cmp2_out(comparator_two_output_in),
        .tmr8_out(eight_bit_timer_count_in));
    // compare one value and count the outcome
    task automatic check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    // n counter clock pulses, one per system cycle
    task automatic ticks(input int n);
        count_tick_in = 1;
        cyc(n);
        count_tick_in = 0;
        cyc(1);
    endtask
    // software writes low byte then high byte
    task automatic wr_count(input logic [15:0] v);
        wr_data_in = v[7:0];
        wr_low_in = 1;
        cyc(1);
        wr_low_in = 0;
        wr_data_in = v[15:8];
        wr_high_in = 1;
        cyc(1);
        wr_high_in = 0;
    endtask
    task automatic pulse;
        pin_cmd = 1;
        cyc(10);
        pin_cmd = 0;
        cyc(8);
    endtask
    task automatic clear_flags;
        gate_flag_clear_in = 1;
        ovf_flag_clear_in = 1;
        cyc(1);
        gate_flag_clear_in = 0;
        ovf_flag_clear_in = 0;
    endtask
    task automatic wrap_up;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        cyc(20000);
        err_total++;
        wrap_up();
    end
    initial begin
        cyc(10);
        rst_in = 0;
        check("count", cnt, 16'h0000);
        ticks(5);
        check("count", cnt, 16'h0000);
        counter_on_in = 1;
        ticks(5);
        check("count", cnt, 16'h0005);
        wr_count(16'hFFFF);
        irq_cfg_in = 4'hB;  // flag still clear from reset
        ticks(1);
        check("count", cnt, 16'h0000);
        check("ovf flag", 16'(overflow_flag_out), 16'h0001);
        check("irq", 16'(irq_out), 16'h0001);
        irq_cfg_in.global_irq_enable = 0;
        cyc(1);
        check("irq", 16'(irq_out), 16'h0000);
        clear_flags();
        check("ovf flag", 16'(overflow_flag_out), 16'h0000);
        gate_cfg_in = 6'h30;  // gated, active-high, pin source
        cyc(6);
        ticks(4);
        check("count", cnt, 16'h0000);
        pin_cmd = 1;
        cyc(6);
        ticks(4);
        check("count", cnt, 16'h0004);
        check("gate level", 16'(gate_level_status_out), 16'h0001);
        clear_flags();
        pin_cmd = 0;
        cyc(6);
        check("gate flag", 16'(gate_event_flag_out), 16'h0001);
        clear_flags();
        gate_cfg_in.gate_enable = 0;
        pin_cmd = 1;
        cyc(6);
        check("gate level", 16'(gate_level_status_out), 16'h0001);
        pin_cmd = 0;
        cyc(6);
        check("gate flag", 16'(gate_event_flag_out), 16'h0001);
        clear_flags();
        for (int i = 0; i < 4; i++) begin
            gate_cfg_in.gate_source_select = 2'(2 + i % 2);
            cmp_sync_in = i[1];
            c1_cmd = (i % 2 == 0);
            c2_cmd = (i % 2 == 1);
            cyc(6);
            check("gate level", 16'(gate_level_status_out), 16'h0001);
            c1_cmd = 0;
            c2_cmd = 0;
            cyc(6);
            check("gate flag", 16'(gate_event_flag_out), 16'h0001);
            clear_flags();
        end
        gate_cfg_in.gate_source_select = 2'h1;
        cyc(6);
        clear_flags();
        tmr_run = 1;
        cyc(270);
        tmr_run = 0;
        check("gate flag", 16'(gate_event_flag_out), 16'h0001);
        gate_cfg_in = 6'h34;  // gated, active-high, single pulse, pin
        cyc(6);
        wr_count(16'h0000);
        count_tick_in = 1;
        arm_set_in = 1;
        cyc(1);
        arm_set_in = 0;
        check("arm", 16'(gate_pulse_arm_out), 16'h0001);
        cyc(6);
        check("count", cnt, 16'h0000);
        pulse();
        check("arm", 16'(gate_pulse_arm_out), 16'h0000);
        held = cnt;
        check("pulse counted", 16'(held != 16'h0000), 16'h0001);
        pulse();
        check("count", cnt, held);
        wr_count(16'h0000);
        gate_cfg_in.gate_toggle_enable = 1; // polarity left alone
        arm_set_in = 1;
        cyc(1);
        arm_set_in = 0;
        repeat (2) pulse();
        check("toggle arm", 16'(gate_pulse_arm_out), 16'h0000);
        check("full cycle", 16'(cnt > 16'h000A), 16'h0001);
        count_tick_in = 0;
        gate_cfg_in = 6'h00;
        arm_clear_in = 1;
        cyc(1);
        arm_clear_in = 0;
        clear_flags();
        wr_count(16'h0010);
        capture_mode_in = 1;
        capture_event_in = 1;
        cyc(1);
        capture_event_in = 0;
        capture_mode_in = 0;
        check("capture", compare_capture_pair_out, 16'h0010);
        compare_value_in = 16'h0014;
        compare_mode_in = 1;
        special_trig_en_in = 1; // synchronised clock kept
        ticks(10);
        check("period", 16'(cnt < 16'h0014), 16'h0001);
        check("ovf flag", 16'(overflow_flag_out), 16'h0000);
        special_trig_en_in = 0;
        compare_mode_in = 0;
        wr_count(16'h0000);
        sleep_in = 1;
        ticks(3);
        check("count", cnt, 16'h0000);
        ext_clock_sel_in = 1;
        external_sync_disable_in = 1;
        low_freq_osc_enable_in = 1;
        ticks(3);
        check("count", cnt, 16'h0003);
        check("osc", 16'(osc_run_out), 16'h0001);
        wrap_up();
    end
endmodule // tb_gated_counter
